// ===== include/txdm_pkg.sv
// txdm_pkg: constants for the transmit descriptor threshold and delay block
package txdm_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] TX_DESCRIPTOR_CONTROL_OFS = 16'h3828;
    localparam logic [15:0] TX_ABSOLUTE_IRQ_DELAY_OFS = 16'h382c;
    localparam logic [15:0] TX_DESC_STATUS_OFS = 16'h3830;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PREFETCH_LEVEL_LSB = 0;
    localparam int HOST_AVAIL_LEVEL_LSB = 8;
    localparam int WRITEBACK_LEVEL_LSB = 16;
    localparam int UNIT_SELECT_BIT = 24;
    localparam int RING_LOW_LEVEL_LSB = 25;
    localparam int LEVEL_W = 6;
    localparam int RING_LOW_W = 7;
    localparam int DELAY_VALUE_W = 16;
    localparam int STAT_ABS_RUN_BIT = 16;
    localparam int STAT_DEL_RUN_BIT = 17;
    localparam int STAT_PREFETCH_BIT = 18;
    localparam int STAT_COUNTING_BIT = 19;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] TX_DESCRIPTOR_CONTROL_RST = 32'h0000_0000;
    localparam logic [15:0] DELAY_VALUE_RST = 16'h0000;

    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int DESC_BYTES = 16;
    localparam int RING_LOW_UNIT = 8;
    localparam int TICK_NS = 1024;
    localparam int CLK_NS = 8;
    localparam int TICK_CYCLES = (TICK_NS / CLK_NS) < 1 ? 1 : (TICK_NS / CLK_NS);
    localparam int THR_W = 10;
    localparam int CNT_W = 16;
endpackage : txdm_pkg

// ===== hw/txdm_core.sv
// txdm_core: transmit descriptor fetch/write-back thresholds and interrupt delay timers
// ************************************************************
// Functional notes
// - thresholds in cache lines or 16-byte descriptors
// - unit_select set writes back every descriptor
// - prefetch considered below prefetch_level on chip
// - prefetch needs host_avail_level host descriptors
// - write back only at writeback_level unless flushed
// - zero writeback_level writes each descriptor immediately
// - counting starts with a report_status descriptor, which is itself counted
// - bursting may write back unrequested descriptors
// - ring_low_cause on step to eight times level
// - zero ring_low_level never raises ring_low_cause
// - delay_value ticks 1.024us, zero disables
// - absolute timer only for report and delay flags
// - countdown starts on transmit, expiry sets written
// - immediate or delay expiry stops absolute timer
// - absolute delay upper half reads zero
// - delay timer reloads on each scheduled completion
// - absolute or immediate interrupt halts reloaded delay
// ************************************************************
`timescale 1ns/1ps
module txdm_core #(
    parameter int CACHE_LINE_BYTES = 256,
    parameter int ONCHIP_W = 7
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic [ONCHIP_W-1:0] ONCHIP_UNPROC_I,
    input wire logic [15:0] HOST_AVAIL_I,
    input wire logic [15:0] WAITING_CNT_I,
    input wire logic DESC_DONE_I,
    input wire logic DESC_RS_I,
    input wire logic DESC_IDE_I,
    input wire logic FLUSH_I,
    input wire logic [15:0] DELAY_TIMER_VALUE_I,
    output logic PREFETCH_REQ_O,
    output logic WB_REQ_O,
    output logic [9:0] WB_COUNT_O,
    output logic RING_LOW_CAUSE_O,
    output logic TX_WRITTEN_CAUSE_O
);
    localparam int DESC_PER_LINE = CACHE_LINE_BYTES / txdm_pkg::DESC_BYTES;

    // converts a threshold field into descriptors
    function automatic logic [9:0] to_desc(input logic [5:0] v, input logic g);
        logic [31:0] prod;
        prod = 32'(v) * 32'(DESC_PER_LINE);
        to_desc = g ? {4'h0, v} : prod[9:0];
    endfunction : to_desc

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] ctl_q, ctl_d;
    logic [15:0] abs_val_q, abs_val_d;
    logic [31:0] rdata_q, rdata_d;
    logic [5:0] pf_lvl, ha_lvl, wb_lvl;
    logic unit_select;
    logic [6:0] rl_lvl;
    logic [9:0] pf_thr, ha_thr, wb_thr;
    logic [9:0] pend_q, pend_d;
    logic counting_q, counting_d;
    logic wb_req_q, wb_req_d;
    logic wb_flush_q, wb_flush_d;
    logic [9:0] wb_cnt_q, wb_cnt_d;
    logic abs_run_q, abs_run_d, del_run_q, del_run_d;
    logic [15:0] abs_cnt_q, abs_cnt_d, del_cnt_q, del_cnt_d;
    logic [6:0] tick_cnt_q, tick_cnt_d;
    logic tick;
    logic written_q, written_d;
    logic [15:0] wait_prev_q;
    logic ring_low_q, ring_low_d;
    logic [15:0] rl_thr;
    logic imm_irq, sched, abs_exp, del_exp, counted, flush_now;

    assign pf_lvl = ctl_q[txdm_pkg::PREFETCH_LEVEL_LSB +: txdm_pkg::LEVEL_W];
    assign ha_lvl = ctl_q[txdm_pkg::HOST_AVAIL_LEVEL_LSB +: txdm_pkg::LEVEL_W];
    assign wb_lvl = ctl_q[txdm_pkg::WRITEBACK_LEVEL_LSB +: txdm_pkg::LEVEL_W];
    assign unit_select = ctl_q[txdm_pkg::UNIT_SELECT_BIT];
    assign rl_lvl = ctl_q[txdm_pkg::RING_LOW_LEVEL_LSB +: txdm_pkg::RING_LOW_W];
    assign pf_thr = to_desc(pf_lvl, unit_select);
    assign ha_thr = to_desc(ha_lvl, unit_select);
    assign wb_thr = to_desc(wb_lvl, unit_select);

    always_comb
    begin
        ctl_d = ctl_q;
        abs_val_d = abs_val_q;
        rdata_d = 32'h0000_0000;
        if (REG_WR_I && REG_ADDR_I == txdm_pkg::TX_DESCRIPTOR_CONTROL_OFS)
        begin
            // reserved bits are dropped so they read back as zero
            ctl_d = REG_WDATA_I & 32'hff3f_3f3f;
        end
        else if (REG_WR_I && REG_ADDR_I == txdm_pkg::TX_ABSOLUTE_IRQ_DELAY_OFS)
        begin
            abs_val_d = REG_WDATA_I[15:0];
        end
        if (REG_RD_I && REG_ADDR_I == txdm_pkg::TX_DESCRIPTOR_CONTROL_OFS)
        begin
            rdata_d = ctl_q;
        end
        else if (REG_RD_I && REG_ADDR_I == txdm_pkg::TX_ABSOLUTE_IRQ_DELAY_OFS)
        begin
            rdata_d = {16'h0000, abs_val_q};
        end
        else if (REG_RD_I && REG_ADDR_I == txdm_pkg::TX_DESC_STATUS_OFS)
        begin
            rdata_d = {12'h000, counting_q, PREFETCH_REQ_O, del_run_q, abs_run_q,
                6'h00, pend_q};
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ctl_q <= txdm_pkg::TX_DESCRIPTOR_CONTROL_RST;
            abs_val_q <= txdm_pkg::DELAY_VALUE_RST;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ctl_q <= ctl_d;
            abs_val_q <= abs_val_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA_O = rdata_q;

    // ************************************************************
    // prefetch decision
    // ************************************************************
    // fetch only when low on chip and host has enough
    assign PREFETCH_REQ_O = (10'(ONCHIP_UNPROC_I) < pf_thr) && (HOST_AVAIL_I != 16'h0000)
        && (HOST_AVAIL_I >= {6'h00, ha_thr});

    // ************************************************************
    // delay timers
    // ************************************************************
    // only descriptors with both flags are scheduled
    assign sched = DESC_DONE_I && DESC_RS_I && DESC_IDE_I;
    assign imm_irq = DESC_DONE_I && DESC_RS_I && !DESC_IDE_I;
    assign tick = (tick_cnt_q == 7'(txdm_pkg::TICK_CYCLES - 1));
    assign abs_exp = tick && abs_run_q && (abs_cnt_q <= 16'h0001);
    assign del_exp = tick && del_run_q && (del_cnt_q <= 16'h0001);

    always_comb
    begin
        tick_cnt_d = tick ? 7'h00 : tick_cnt_q + 7'h01;
        abs_run_d = abs_run_q;
        abs_cnt_d = abs_cnt_q;
        del_run_d = del_run_q;
        del_cnt_d = del_cnt_q;
        if (tick && abs_run_q)
        begin
            abs_cnt_d = abs_exp ? 16'h0000 : abs_cnt_q - 16'h0001;
            abs_run_d = !abs_exp;
        end
        if (tick && del_run_q)
        begin
            del_cnt_d = del_exp ? 16'h0000 : del_cnt_q - 16'h0001;
            del_run_d = !del_exp;
        end
        // delay expiry stops the absolute timer
        if (del_exp)
        begin
            abs_run_d = 1'b0;
        end
        // absolute expiry halts a reloaded delay timer
        if (abs_exp)
        begin
            del_run_d = 1'b0;
            del_cnt_d = DELAY_TIMER_VALUE_I;
        end
        if (imm_irq)
        begin
            abs_run_d = 1'b0;
            del_run_d = 1'b0;
            del_cnt_d = DELAY_TIMER_VALUE_I;
        end
        else if (sched)
        begin
            // restart delay countdown from programmed value
            del_run_d = 1'b1;
            del_cnt_d = DELAY_TIMER_VALUE_I;
            if (abs_val_q != 16'h0000 && (!abs_run_q || abs_exp || del_exp))
            begin
                abs_run_d = 1'b1;
                abs_cnt_d = abs_val_q;
            end
        end
        // expiry or immediate completion raises the cause
        written_d = imm_irq || abs_exp || del_exp;
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            tick_cnt_q <= 7'h00;
            abs_run_q <= 1'b0;
            abs_cnt_q <= 16'h0000;
            del_run_q <= 1'b0;
            del_cnt_q <= 16'h0000;
            written_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            abs_run_q <= abs_run_d;
            abs_cnt_q <= abs_cnt_d;
            del_run_q <= del_run_d;
            del_cnt_q <= del_cnt_d;
            written_q <= written_d;
        end
    end

    assign TX_WRITTEN_CAUSE_O = written_q;

    // ************************************************************
    // write-back accumulation
    // ************************************************************
    // which processed descriptors are counted
    assign counted = DESC_DONE_I && (unit_select || DESC_RS_I || counting_q);
    // timer expiries act as a flush so pending entries are not stranded
    assign flush_now = FLUSH_I || written_d;

    always_comb
    begin
        pend_d = pend_q + (counted ? 10'h001 : 10'h000);
        counting_d = counting_q || (DESC_DONE_I && DESC_RS_I);
        wb_req_d = 1'b0;
        wb_flush_d = 1'b0;
        wb_cnt_d = wb_cnt_q;
        // zero level writes each one back at once
        // otherwise wait for the level or a flush
        if (pend_d != 10'h000 && (wb_thr == 10'h000 || pend_d >= wb_thr || flush_now))
        begin
            wb_req_d = 1'b1;
            wb_flush_d = flush_now && pend_d < wb_thr;
            wb_cnt_d = pend_d;
            pend_d = 10'h000;
            counting_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pend_q <= 10'h000;
            counting_q <= 1'b0;
            wb_req_q <= 1'b0;
            wb_flush_q <= 1'b0;
            wb_cnt_q <= 10'h000;
        end
        else
        begin
            pend_q <= pend_d;
            counting_q <= counting_d;
            wb_req_q <= wb_req_d;
            wb_flush_q <= wb_flush_d;
            wb_cnt_q <= wb_cnt_d;
        end
    end

    assign WB_REQ_O = wb_req_q;
    assign WB_COUNT_O = wb_cnt_q;

    // ************************************************************
    // ring low detection
    // ************************************************************
    assign rl_thr = 16'(rl_lvl) * 16'(txdm_pkg::RING_LOW_UNIT);

    always_comb
    begin
        // fires on the exact step, never when level is zero
        ring_low_d = (rl_lvl != 7'h00) && (wait_prev_q == rl_thr + 16'h0001)
            && (WAITING_CNT_I == rl_thr);
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            wait_prev_q <= 16'h0000;
            ring_low_q <= 1'b0;
        end
        else
        begin
            wait_prev_q <= WAITING_CNT_I;
            ring_low_q <= ring_low_d;
        end
    end

    assign RING_LOW_CAUSE_O = ring_low_q;

    // ************************************************************
    // checks
    // ************************************************************
    prefetch_level_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        PREFETCH_REQ_O |-> 10'(ONCHIP_UNPROC_I) < pf_thr)
        else $error("prefetch with enough descriptors on chip");
    prefetch_host_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        PREFETCH_REQ_O |-> HOST_AVAIL_I >= {6'h00, ha_thr})
        else $error("prefetch without enough host descriptors");
    wb_immediate_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (DESC_DONE_I && wb_lvl == 6'h00 && (DESC_RS_I || unit_select)) |=> WB_REQ_O)
        else $error("descriptor not written back at once");
    wb_level_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (WB_REQ_O && !wb_flush_q && $stable(wb_thr)) |-> WB_COUNT_O >= wb_thr)
        else $error("write back below level without flush");
    unit_select_all_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (DESC_DONE_I && unit_select) |=> (pend_q == $past(pend_q) + 10'h001) || WB_REQ_O)
        else $error("descriptor skipped in descriptor units");
    rs_start_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (DESC_DONE_I && !DESC_RS_I && !unit_select && !counting_q && !flush_now)
        |=> pend_q == $past(pend_q) && !WB_REQ_O)
        else $error("counted before a report descriptor");
    ring_low_hit_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (rl_lvl != 7'h00 && $past(WAITING_CNT_I) == rl_thr + 16'h0001
        && WAITING_CNT_I == rl_thr) |=> RING_LOW_CAUSE_O)
        else $error("ring low step missed");
    ring_low_off_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        $past(rl_lvl) == 7'h00 |-> !RING_LOW_CAUSE_O)
        else $error("ring low raised while disabled");
    abs_off_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (abs_val_q == 16'h0000 && !abs_run_q) |=> !abs_run_q)
        else $error("absolute timer ran while disabled");
    abs_stop_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (imm_irq || (del_exp && !sched)) |=> !abs_run_q)
        else $error("absolute timer survived other interrupt");
    abs_hold_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (abs_run_q && sched && !tick) |=> abs_cnt_q == $past(abs_cnt_q))
        else $error("running absolute timer reloaded");
    del_halt_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (abs_exp && !sched) |=> !del_run_q && del_cnt_q == $past(DELAY_TIMER_VALUE_I))
        else $error("delay timer not halted and reloaded");
    written_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        abs_exp |=> TX_WRITTEN_CAUSE_O)
        else $error("absolute expiry raised no cause");
    upper_zero_a: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (REG_RD_I && REG_ADDR_I == txdm_pkg::TX_ABSOLUTE_IRQ_DELAY_OFS)
        |=> REG_RDATA_O[31:16] == 16'h0000)
        else $error("absolute delay upper half not zero");
endmodule : txdm_core

// ===== tb/txdm_host_model.sv
// txdm_host_model: host memory side, posts descriptors and absorbs write-backs
`timescale 1ns/1ps
module txdm_host_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] posted_i,
    input wire logic wb_req_i,
    input wire logic [9:0] wb_count_i,
    output logic [15:0] host_avail_o,
    output logic [15:0] wb_total_o
);
    logic [15:0] wb_total_q;
    assign host_avail_o = posted_i;
    assign wb_total_o = wb_total_q;
    // total descriptors written back, checked against those counted for write-back
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wb_total_q <= 16'h0000;
        else if (wb_req_i)
            wb_total_q <= wb_total_q + 16'(wb_count_i);
    end
endmodule : txdm_host_model

// ===== tb/test_tx_descriptor_threshold_irq_moderation.sv
// test_tx_descriptor_threshold_irq_moderation: self-checking bench for txdm_core
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module test_tx_descriptor_threshold_irq_moderation;
    localparam logic [15:0] CTL = txdm_pkg::TX_DESCRIPTOR_CONTROL_OFS;
    localparam logic [15:0] ABS = txdm_pkg::TX_ABSOLUTE_IRQ_DELAY_OFS;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'h0, rd_s = 1'h0, done = 1'h0, rs = 1'h0, delay_enable_flag = 1'h0, flush = 1'h0;
    logic [6:0] onchip = 7'h00;
    logic [15:0] posted = 16'h0000, waiting = 16'h0000, dly = 16'h0000;
    logic [15:0] host_avail, wb_total;
    logic [31:0] rdata, d;
    logic pre, wb, ring, txw, hit;
    logic [9:0] wbc;
    int fail_count = 0, compares = 0, n, i;
    int wv[9] = '{18, 17, 16, 15, 16, 17, 16, 1, 0};

    always #4 clk = ~clk;

    txdm_core #(.CACHE_LINE_BYTES(256), .ONCHIP_W(7)) i_dut (.MCLK_I(clk), .RST_B_I(rst_b),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
        .REG_RDATA_O(rdata), .ONCHIP_UNPROC_I(onchip), .HOST_AVAIL_I(host_avail),
        .WAITING_CNT_I(waiting), .DESC_DONE_I(done), .DESC_RS_I(rs), .DESC_IDE_I(delay_enable_flag),
        .FLUSH_I(flush), .DELAY_TIMER_VALUE_I(dly), .PREFETCH_REQ_O(pre), .WB_REQ_O(wb),
        .WB_COUNT_O(wbc), .RING_LOW_CAUSE_O(ring), .TX_WRITTEN_CAUSE_O(txw));

    txdm_host_model i_host (.clk_i(clk), .rst_b_i(rst_b), .posted_i(posted), .wb_req_i(wb),
        .wb_count_i(wbc), .host_avail_o(host_avail), .wb_total_o(wb_total));

    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic [31:0] ctl(input logic [6:0] rl, input logic g,
        input logic [5:0] w, input logic [5:0] h, input logic [5:0] p);
        ctl = {rl, g, 2'h0, w, 2'h0, h, 2'h0, p};
    endfunction : ctl

    task close_out;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    task rst_dut;
        rst_b <= 1'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
    endtask : rst_dut

    task wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'h1;
        @(posedge clk);
        wr_s <= 1'h0;
    endtask : wr

    task rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge clk);
        rd_s <= 1'h0;
        #1;
        v = rdata;
    endtask : rd

    // one processed descriptor; outputs of its edge are settled on return
    task desc(input logic r, input logic e);
        @(posedge clk);
        done <= 1'h1;
        rs <= r;
        delay_enable_flag <= e;
        @(posedge clk);
        done <= 1'h0;
        #1;
    endtask : desc

    task wait_irq(input int mx, output int k);
        k = 0;
        while (k < mx && txw !== 1'h1)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask : wait_irq

    task pf(input logic [31:0] c, input logic [6:0] on, input logic [15:0] av, input logic e);
        wr(CTL, c);
        @(posedge clk);
        onchip <= on;
        posted <= av;
        @(posedge clk);
        #1;
        `CHK("prefetch", e, pre)
    endtask : pf

    task test_end(input string nm);
        $display("test %s done, mismatches %0d", nm, fail_count);
    endtask : test_end

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        rst_dut;
        rd(CTL, d);
        `CHK("ctl reset", txdm_pkg::TX_DESCRIPTOR_CONTROL_RST, d)
        rd(ABS, d);
        `CHK("abs reset", {16'h0000, txdm_pkg::DELAY_VALUE_RST}, d)
        // prefetch kept at 47, the two reserved bits above its 6-bit field dropped
        wr(CTL, 32'hffff_ffef);
        rd(CTL, d);
        `CHK("ctl fields", 32'hff3f_3f2f, d)
        wr(ABS, 32'hffff_1234);
        rd(ABS, d);
        `CHK("abs upper", 32'h0000_1234, d)
        rd(16'h3834, d);
        `CHK("unmapped", 32'h0000_0000, d)
        test_end("registers");
        pf(ctl(7'h0, 1'h1, 6'h0, 6'h3, 6'h4), 7'h04, 16'h0009, 1'h0);
        pf(ctl(7'h0, 1'h1, 6'h0, 6'h3, 6'h4), 7'h03, 16'h0002, 1'h0);
        pf(ctl(7'h0, 1'h1, 6'h0, 6'h3, 6'h4), 7'h03, 16'h0003, 1'h1);
        pf(ctl(7'h0, 1'h0, 6'h0, 6'h1, 6'h1), 7'h0f, 16'h0010, 1'h1);
        pf(ctl(7'h0, 1'h0, 6'h0, 6'h1, 6'h1), 7'h10, 16'h0010, 1'h0);
        pf(ctl(7'h0, 1'h0, 6'h0, 6'h1, 6'h1), 7'h0f, 16'h000f, 1'h0);
        test_end("prefetch");
        // timers kept far from expiry so only the threshold releases
        rst_dut;
        dly <= 16'h0100;
        wr(ABS, 32'h0000_0100);
        wr(CTL, ctl(7'h0, 1'h0, 6'h1, 6'h0, 6'h0));
        for (i = 0; i < 18; i++)
        begin
            desc(i == 2, i == 2);
            `CHK("wb burst", i == 17, wb)
        end
        `CHK("wb count", 10'h010, wbc)
        @(posedge clk);
        #1;
        `CHK("host words", 16'h0010, wb_total)
        rst_dut;
        wr(ABS, 32'h0000_0100);
        wr(CTL, ctl(7'h0, 1'h1, 6'h2, 6'h0, 6'h0));
        desc(1'h0, 1'h0);
        `CHK("all wb 1st", 1'h0, wb)
        desc(1'h0, 1'h0);
        `CHK("all wb 2nd", 1'h1, wb)
        `CHK("all wb cnt", 10'h002, wbc)
        desc(1'h0, 1'h0);
        `CHK("flush held", 1'h0, wb)
        @(posedge clk);
        flush <= 1'h1;
        @(posedge clk);
        flush <= 1'h0;
        #1;
        `CHK("flush wb", 1'h1, wb)
        `CHK("flush cnt", 10'h001, wbc)
        rst_dut;
        desc(1'h1, 1'h0);
        `CHK("single wb", 1'h1, wb)
        `CHK("single cnt", 10'h001, wbc)
        `CHK("immediate", 1'h1, txw)
        test_end("writeback");
        wr(CTL, ctl(7'h2, 1'h1, 6'h0, 6'h0, 6'h0));
        for (i = 0; i < 9; i++)
        begin
            if (i == 7)
                wr(CTL, 32'h0000_0000);
            @(posedge clk);
            waiting <= 16'(wv[i]);
            hit = 1'h0;
            repeat (2)
            begin
                @(posedge clk);
                #1;
                hit = hit | ring;
            end
            `CHK("ring low", i == 2 || i == 6, hit)
        end
        test_end("ring");
        rst_dut;
        dly <= 16'h0001;
        wr(ABS, 32'h0000_0002);
        desc(1'h0, 1'h1);
        wait_irq(400, n);
        `CHK("unscheduled", 1'h1, n == 400)
        desc(1'h1, 1'h1);
        wait_irq(400, n);
        `CHK("delay fire", 1'h1, n <= 132)
        @(posedge clk);
        #1;
        wait_irq(400, n);
        `CHK("abs halted", 1'h1, n == 400)
        rst_dut;
        dly <= 16'h0100;
        wr(ABS, 32'h0000_0002);
        desc(1'h1, 1'h1);
        // second completion lands after a tick, so a reload would show late
        repeat (200) @(posedge clk);
        desc(1'h1, 1'h1);
        wait_irq(400, n);
        `CHK("abs bound", 1'h1, n + 202 >= 129 && n + 202 <= 260)
        rst_dut;
        dly <= 16'h0003;
        desc(1'h1, 1'h1);
        wait_irq(600, n);
        `CHK("abs off", 1'h1, n >= 250 && n <= 390)
        rst_dut;
        dly <= 16'h0002;
        desc(1'h1, 1'h1);
        repeat (200) @(posedge clk);
        desc(1'h1, 1'h1);
        wait_irq(400, n);
        `CHK("delay reload", 1'h1, n >= 120 && n <= 260)
        test_end("timers");
        close_out;
    end

    // tests need well under 3000 cycles; allow well over ten times that
    initial
    begin
        #600000;
        fail_count++;
        $display("watchdog expired");
        close_out;
    end
endmodule : test_tx_descriptor_threshold_irq_moderation
